// >>> core/lsd_blink.sv
// square wave divider counting reference clock ticks
`timescale 1ns/1ps
module lsd_blink #(
  parameter int HALF = 2
) (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic tick,
  output logic      phase_q,
  output logic      wrap
);

  // ----------------------------------------------------------------
  // half period counter
  // ----------------------------------------------------------------
  localparam logic [lsd_pkg::HALF_CNT_W-1:0] LAST =
    lsd_pkg::HALF_CNT_W'(HALF - 1);

  logic [lsd_pkg::HALF_CNT_W-1:0] cnt_q;
  logic [lsd_pkg::HALF_CNT_W-1:0] cnt_d;
  logic                           half_end;
  logic                           phase_d;

  assign half_end = tick && (cnt_q == LAST);
  assign cnt_d    = half_end ? '0 : (tick ? cnt_q + 1'b1 : cnt_q);
  assign phase_d  = half_end ? ~phase_q : phase_q;
  assign wrap     = half_end && phase_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_q   <= '0;
      phase_q <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      phase_q <= phase_d;
    end
  end

endmodule

// >>> core/lsd_pkg.sv
// constants and types of the network status indicator block
package lsd_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int REF_CLK_HZ     = 25_000_000;
  localparam int BLINK_SLOW_HZ  = 10;
  localparam int BLINK_FAST_HZ  = 20;
  localparam int SLOW_HALF_REFS = REF_CLK_HZ / (2 * BLINK_SLOW_HZ);
  localparam int FAST_HALF_REFS = REF_CLK_HZ / (2 * BLINK_FAST_HZ);
  localparam int HALF_CNT_W     = 21;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [3:0]  CTRL_OFS      = 4'h0;
  localparam logic [3:0]  STAT_OFS      = 4'h4;
  localparam int          CTRL_MODE_BIT = 0;
  localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
  localparam int          STAT_LA_BIT   = 0;
  localparam int          STAT_SPD_BIT  = 1;
  localparam int          STAT_DC_BIT   = 2;
  localparam int          STAT_AUX_BIT  = 3;
  localparam int          STAT_MAIN_BIT = 4;
  localparam int          STAT_MODE_BIT = 5;
  localparam int          STAT_LINK_BIT = 6;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic {
    INDICATOR_MODE_ONE,
    INDICATOR_MODE_TWO
  } lsd_mode_t;

endpackage

// >>> core/lsd_top.sv
// network status indicator driver with avalon register slave
`timescale 1ns/1ps
module lsd_top #(
  parameter int SLOW_HALF = lsd_pkg::SLOW_HALF_REFS,
  parameter int FAST_HALF = lsd_pkg::FAST_HALF_REFS
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        ref_clock_in,
  output logic             ref_clock_out,
  input  wire logic        link_good,
  input  wire logic        rx_active,
  input  wire logic        tx_active,
  input  wire logic        speed_100,
  input  wire logic        full_duplex,
  input  wire logic        collision,
  input  wire logic        rom_addr16_in,
  input  wire logic        aux_power_detect,
  input  wire logic        main_power_detect,
  output logic             link_activity_indicator,
  output logic             speed_indicator,
  output logic             duplex_collision_indicator,
  output logic             rom_addr16_pin,
  output logic             aux_power_ok,
  output logic             main_power_ok
);

  // ----------------------------------------------------------------
  // bus slave decode
  // ----------------------------------------------------------------
  logic              ack_q;
  logic              req;
  logic              wr_commit;
  logic              hit_ctrl;
  logic              hit_stat;
  logic [31:0]       stat_word;
  logic [31:0]       rd_mux;
  logic [31:0]       rdata_q;
  lsd_pkg::lsd_mode_t mode_q;
  lsd_pkg::lsd_mode_t mode_d;

  assign req             = avs_read || avs_write;
  assign avs_waitrequest = req && !ack_q;
  assign wr_commit       = avs_write && ack_q;
  assign hit_ctrl        = (avs_address == lsd_pkg::CTRL_OFS);
  assign hit_stat        = (avs_address == lsd_pkg::STAT_OFS);
  assign avs_readdata    = rdata_q;

  assign rd_mux = hit_ctrl ? {31'h0000_0000, mode_q} :
                  hit_stat ? stat_word : 32'h0000_0000;

  // mode changes only on a committed write to the control word
  assign mode_d = (wr_commit && hit_ctrl && avs_byteenable[0]) ?
                  lsd_pkg::lsd_mode_t'(
                    avs_writedata[lsd_pkg::CTRL_MODE_BIT]) :
                  mode_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
      mode_q  <= lsd_pkg::lsd_mode_t'(
                   lsd_pkg::CTRL_RST[lsd_pkg::CTRL_MODE_BIT]);
    end else begin
      ack_q  <= req && !ack_q;
      mode_q <= mode_d;
      if (avs_read && !ack_q) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // reference clock ticks and blink dividers
  // ----------------------------------------------------------------
  localparam int HALVES [2] = '{SLOW_HALF, FAST_HALF};

  logic       ref_prev_q;
  logic       ref_out_q;
  logic       ref_tick;
  logic [1:0] phase;
  logic [1:0] wrap;

  assign ref_tick      = ref_clock_in && !ref_prev_q;
  assign ref_clock_out = ref_out_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ref_prev_q <= 1'b0;
      ref_out_q  <= 1'b0;
    end else begin
      ref_prev_q <= ref_clock_in;
      ref_out_q  <= !ref_clock_in;
    end
  end

  // index 0 gives 10 Hz, index 1 gives 20 Hz
  for (genvar g = 0; g < 2; g++) begin : g_rate
    lsd_blink #(
      .HALF (HALVES[g])
    ) u_blink (
      .core_clk (core_clk),
      .rst      (rst),
      .tick     (ref_tick),
      .phase_q  (phase[g]),
      .wrap     (wrap[g])
    );
  end

  // ----------------------------------------------------------------
  // activity and collision stretch
  // ----------------------------------------------------------------
  logic act_seen_q;
  logic act_seen_d;
  logic col_seen_q;
  logic col_seen_d;
  logic activity;

  assign activity = rx_active || tx_active;
  // a new event in the clearing cycle keeps the flag set
  assign act_seen_d = activity || (act_seen_q && !wrap[0]);
  assign col_seen_d = (collision && !full_duplex) ||
                      (col_seen_q && !wrap[1]);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      act_seen_q <= 1'b0;
      col_seen_q <= 1'b0;
    end else begin
      act_seen_q <= act_seen_d;
      col_seen_q <= col_seen_d;
    end
  end

  // ----------------------------------------------------------------
  // lamp selection
  // ----------------------------------------------------------------
  logic mode_two;
  logic la_one;
  logic la_two;
  logic dc_one;
  logic spd_d;
  logic la_d;
  logic dc_d;
  logic rom_d;

  assign mode_two = (mode_q == lsd_pkg::INDICATOR_MODE_TWO);
  assign la_one   = act_seen_q ? phase[0] : link_good;
  assign la_two   = act_seen_q && phase[0];
  assign dc_one   = full_duplex ? 1'b1 :
                    (col_seen_q && phase[1]);
  assign la_d     = mode_two ? la_two : la_one;
  assign spd_d    = mode_two ? (link_good && speed_100) :
                    speed_100;
  assign dc_d     = mode_two ? (link_good && !speed_100) :
                    dc_one;
  assign rom_d    = mode_two ? dc_one : rom_addr16_in;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      link_activity_indicator    <= 1'b0;
      speed_indicator            <= 1'b0;
      duplex_collision_indicator <= 1'b0;
      rom_addr16_pin             <= 1'b0;
      aux_power_ok               <= 1'b0;
      main_power_ok              <= 1'b0;
    end else begin
      link_activity_indicator    <= la_d;
      speed_indicator            <= spd_d;
      duplex_collision_indicator <= dc_d;
      rom_addr16_pin             <= rom_d;
      aux_power_ok               <= aux_power_detect;
      main_power_ok              <= main_power_detect;
    end
  end

  // ----------------------------------------------------------------
  // status word
  // ----------------------------------------------------------------
  always_comb begin
    stat_word                         = 32'h0000_0000;
    stat_word[lsd_pkg::STAT_LA_BIT]   = link_activity_indicator;
    stat_word[lsd_pkg::STAT_SPD_BIT]  = speed_indicator;
    stat_word[lsd_pkg::STAT_DC_BIT]   = duplex_collision_indicator;
    stat_word[lsd_pkg::STAT_AUX_BIT]  = aux_power_ok;
    stat_word[lsd_pkg::STAT_MAIN_BIT] = main_power_ok;
    stat_word[lsd_pkg::STAT_MODE_BIT] = mode_two;
    stat_word[lsd_pkg::STAT_LINK_BIT] = link_good;
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  sequence s_ctrl_write;
    wr_commit && hit_ctrl && avs_byteenable[0];
  endsequence

  sequence s_mode_one_link_quiet;
    !mode_two && link_good && !act_seen_q;
  endsequence

  sequence s_half_collision;
    !mode_two && !full_duplex;
  endsequence

  a_link_steady_one:
    assert property (s_mode_one_link_quiet |=> link_activity_indicator)
    else $error("link lamp not steady in mode one");

  a_act_blink_one:
    assert property ((!mode_two && act_seen_q) |=>
                     (link_activity_indicator == $past(phase[0])))
    else $error("link lamp not following slow blink");

  a_act_off_two:
    assert property ((mode_two && !act_seen_q) |=>
                     !link_activity_indicator)
    else $error("activity lamp lit without activity");

  a_act_blink_two:
    assert property ((mode_two && act_seen_q) |=>
                     (link_activity_indicator == $past(phase[0])))
    else $error("activity lamp not following slow blink");

  a_act_stretch:
    assert property ((rx_active || tx_active) |=> act_seen_q)
    else $error("activity not held for blink");

  a_speed_mode_one:
    assert property (!mode_two |=>
                     (speed_indicator == $past(speed_100)))
    else $error("speed lamp wrong in mode one");

  a_speed_link_two:
    assert property ((mode_two && link_good && speed_100) |=>
                     speed_indicator)
    else $error("100 link lamp off");

  a_speed_ten_two:
    assert property ((mode_two && !speed_100) |=> !speed_indicator)
    else $error("100 link lamp lit at 10 Mb/s");

  a_duplex_steady:
    assert property ((!mode_two && full_duplex) |=>
                     duplex_collision_indicator)
    else $error("duplex lamp off in full duplex");

  a_col_blink_one:
    assert property (s_half_collision |=>
                     (duplex_collision_indicator ==
                      ($past(col_seen_q) && $past(phase[1]))))
    else $error("collision lamp not following fast blink");

  a_col_ignored:
    assert property ((full_duplex && !col_seen_q) |=> !col_seen_q)
    else $error("collision taken in full duplex");

  a_ten_link_two:
    assert property (mode_two |=> (duplex_collision_indicator ==
                     ($past(link_good) && !$past(speed_100))))
    else $error("10 link lamp wrong");

  a_aux_follow:
    assert property (aux_power_detect |=> aux_power_ok)
    else $error("aux power not reported");

  a_aux_drop:
    assert property (!aux_power_detect |=> !aux_power_ok)
    else $error("aux power reported while absent");

  a_main_follow:
    assert property (!main_power_detect |=> !main_power_ok)
    else $error("main power reported while absent");

  a_main_rise:
    assert property (main_power_detect |=> main_power_ok)
    else $error("main power not reported");

  a_rom_pin_two:
    assert property ((mode_two && full_duplex) |=> rom_addr16_pin)
    else $error("rom pin lamp off in full duplex");

  a_rom_col_two:
    assert property ((mode_two && !full_duplex) |=>
                     (rom_addr16_pin ==
                      ($past(col_seen_q) && $past(phase[1]))))
    else $error("rom pin lamp not following collision");

  a_rom_pass_one:
    assert property (!mode_two |=>
                     (rom_addr16_pin == $past(rom_addr16_in)))
    else $error("rom pin not passed through in mode one");

  a_mode_write:
    assert property (s_ctrl_write |=> (mode_q == lsd_pkg::lsd_mode_t'(
                     $past(avs_writedata[lsd_pkg::CTRL_MODE_BIT]))))
    else $error("mode write not taken");

  a_blink_hold:
    assert property (!ref_tick |=> $stable(phase))
    else $error("blink phase moved without reference tick");

  a_ref_feedback:
    assert property (!rst |=>
                     (ref_clock_out == !$past(ref_clock_in)))
    else $error("reference feedback not inverted");

  a_wait_one:
    assert property ($rose(req) |-> avs_waitrequest ##1
                     !avs_waitrequest)
    else $error("bus answer not after one wait cycle");

endmodule

// >>> dv/lsd_board.sv
// board side model: reference oscillator, power detect, lamp timing
`timescale 1ns/1ps
module lsd_board (
  input  wire logic       core_clk,
  input  wire logic       aux_want,
  input  wire logic       main_want,
  input  wire logic [2:0] lamps,
  output logic            ref_clock_in,
  output logic            aux_power_detect,
  output logic            main_power_detect,
  output logic [7:0]      per [3]
);
  logic [7:0] cnt [3];
  logic [2:0] prev;
  // 25 MHz oscillator, free running
  initial begin
    ref_clock_in = 1'b0;
    forever #20 ref_clock_in = ~ref_clock_in;
  end
  assign aux_power_detect  = aux_want;
  assign main_power_detect = main_want;
  // rise to rise lamp period in core cycles
  always @(posedge core_clk) begin
    prev <= lamps;
    for (int i = 0; i < 3; i++) begin
      if (lamps[i] && !prev[i]) begin
        per[i] <= cnt[i];
        cnt[i] <= 8'h01;
      end else begin
        cnt[i] <= cnt[i] + 8'h01;
      end
    end
  end
endmodule

// >>> dv/testbench.sv
// self-checking bench of the status indicator block
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("mismatch at %0t: got %h exp %h", $time, a, e); end end
module testbench;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic [3:0]  avs_byteenable = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [8:0]  stim = 9'h000;
  logic [2:0]  lamps;
  logic        spd;
  logic        aux_ok;
  logic        main_ok;
  logic        ref_in;
  logic        aux_det;
  logic        main_det;
  logic        ref_out;
  logic        ref_seen;
  logic [7:0]  per [3];
  logic [31:0] q;
  int          error_cnt = 0;
  int          n_checks = 0;
  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) ref_seen <= ref_in;
  // ----------------------------------------------------------------
  // design and board
  // ----------------------------------------------------------------
  lsd_top #(.SLOW_HALF(4), .FAST_HALF(2)) DUT (
    .core_clk(core_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ref_clock_in(ref_in), .ref_clock_out(ref_out),
    .link_good(stim[8]), .rx_active(stim[7]), .tx_active(stim[6]),
    .speed_100(stim[5]), .full_duplex(stim[4]), .collision(stim[3]),
    .rom_addr16_in(stim[2]), .aux_power_detect(aux_det),
    .main_power_detect(main_det),
    .link_activity_indicator(lamps[0]), .speed_indicator(spd),
    .duplex_collision_indicator(lamps[1]), .rom_addr16_pin(lamps[2]),
    .aux_power_ok(aux_ok), .main_power_ok(main_ok)
  );
  lsd_board board (
    .core_clk(core_clk), .aux_want(stim[1]), .main_want(stim[0]),
    .lamps(lamps), .ref_clock_in(ref_in), .aux_power_detect(aux_det),
    .main_power_detect(main_det), .per(per)
  );
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // stim order: link rx tx spd duplex collision rom aux main
  task set_in(input logic [8:0] v, input int w);
    @(posedge core_clk);
    stim <= v;
    repeat (w) @(posedge core_clk);
    @(negedge core_clk);
    `CHK(ref_out, !ref_seen)
  endtask
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
           input logic [3:0] be);
    int n;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) begin
      n++;
      if (n > 20) begin
        error_cnt++;
        give_verdict;
      end
      @(posedge core_clk);
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge core_clk);
    `CHK({lamps, spd, aux_ok, main_ok}, 6'h00)
    rst <= 1'b0;
    set_in(9'h136, 4);
    `CHK({lamps, spd}, 4'hf)
    `CHK({aux_ok, main_ok}, 2'h2)
    bus(1'h0, 4'h4, 32'h0, 4'hf);
    `CHK(q, 32'h0000_004f)
    set_in(9'h135, 4);
    `CHK({aux_ok, main_ok}, 2'h1)
    bus(1'h0, 4'h4, 32'h0, 4'hf);
    `CHK(q, 32'h0000_0057)
    $display("test power done");
    set_in(9'h115, 4);
    `CHK(spd, 1'h0)
    set_in(9'h195, 200);
    `CHK(per[0], 8'h40)
    set_in(9'h10d, 200);
    `CHK(per[1], 8'h20)
    set_in(9'h11d, 40);
    `CHK(lamps[1], 1'h1)
    $display("test mode one done");
    bus(1'h1, 4'h0, 32'h1, 4'hf);
    bus(1'h0, 4'h4, 32'h0, 4'hf);
    `CHK(q[5], 1'h1)
    set_in(9'h130, 40);
    `CHK({lamps, spd}, 4'h9)
    set_in(9'h110, 4);
    `CHK({lamps, spd}, 4'hc)
    set_in(9'h030, 4);
    `CHK({lamps, spd}, 4'h8)
    set_in(9'h170, 200);
    `CHK(per[0], 8'h40)
    set_in(9'h168, 200);
    `CHK(per[2], 8'h20)
    $display("test mode two done");
    bus(1'h1, 4'h4, 32'h0, 4'hf);
    bus(1'h1, 4'h0, 32'h0, 4'he);
    bus(1'h0, 4'h4, 32'h0, 4'hf);
    `CHK(q[5], 1'h1)
    bus(1'h0, 4'h8, 32'h0, 4'hf);
    `CHK(q, 32'h0)
    bus(1'h1, 4'h0, 32'h0, 4'hf);
    set_in(9'h130, 70);
    `CHK({lamps, spd}, 4'h7)
    bus(1'h0, 4'h4, 32'h0, 4'hf);
    `CHK(q[5], 1'h0)
    $display("test registers done");
    give_verdict;
  end
endmodule
